// file: hw/cic_evt_if.sv
// Interface: event sensing controls and set pulses between sensor and controller
`timescale 1ns/1ps
interface cic_evt_if #(
	parameter int PB_W = 8
);
	logic edge_rise;
	logic [PB_W-1:0] chg_mask;
	logic ext_set;
	logic chg_set;
	modport sense (
		input edge_rise,
		input chg_mask,
		output ext_set,
		output chg_set
	);
	modport ctrl (
		output edge_rise,
		output chg_mask,
		input ext_set,
		input chg_set
	);
endinterface : cic_evt_if

// file: hw/cic_evt_sense.sv
// Edge sensing for the external pin and masked port B change detection
`timescale 1ns/1ps
module cic_evt_sense #(
	parameter int PB_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ext_pin,
	input wire logic [PB_W-1:0] pb_pins,
	cic_evt_if.sense ev
);
	logic ext_q;
	logic [PB_W-1:0] pb_q;
	logic primed_q;
	logic [PB_W-1:0] diff;

	// ====================================================
	// Previous samples
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_q <= 1'b0;
			pb_q <= '0;
			primed_q <= 1'b0;
		end else begin
			ext_q <= ext_pin;
			pb_q <= pb_pins;
			primed_q <= 1'b1;
		end
	end

	// ====================================================
	// Events
	// No event before the first sample, so reset values never fake an edge
	assign ev.ext_set = primed_q & (ev.edge_rise ? (ext_pin & ~ext_q) : (~ext_pin & ext_q));
	assign diff = (pb_pins ^ pb_q) & ev.chg_mask;
	assign ev.chg_set = primed_q & (|diff);

	AST_CHG_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
		ev.chg_set |-> |((pb_pins ^ $past(pb_pins)) & ev.chg_mask))
		else $error("change event from a masked pin");
	AST_EXT_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
		ev.ext_set |-> ext_pin == ev.edge_rise && $past(ext_pin) != ev.edge_rise)
		else $error("external event on wrong edge");
endmodule : cic_evt_sense

// file: hw/cic_pkg.sv
// Package: register map, field positions, reset values for the core interrupt control
package cic_pkg;
	localparam int APB_AW = 8;
	localparam int PC_W = 13;
	// Register byte offsets
	localparam logic [7:0] OFS_IRQ_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHG_MASK = 8'h04;
	localparam logic [7:0] OFS_T0_COUNT = 8'h08;
	localparam logic [7:0] OFS_OPTION = 8'h0c;
	localparam logic [7:0] OFS_PC_HIGH = 8'h10;
	localparam logic [7:0] OFS_PERIPH_STAT = 8'h14;
	localparam logic [7:0] OFS_SEQ_STAT = 8'h18;
	// irq_control fields
	localparam int B_ALL_EN = 7;
	localparam int B_GRP_EN = 6;
	localparam int B_T0IE = 5;
	localparam int B_EXTIE = 4;
	localparam int B_CHGIE = 3;
	localparam int B_T0F = 2;
	localparam int B_EXTF = 1;
	localparam int B_CHGF = 0;
	// option fields
	localparam int B_EDGE_SEL = 0;
	// seq_stat fields
	localparam int B_WAKE_HOLD = 0;
	localparam int B_VEC_REQ = 1;
	localparam int B_IN_SEQ = 2;
	// Reset values
	localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
	localparam logic [7:0] RST_CHG_MASK = 8'h00;
	localparam logic [7:0] RST_OPTION = 8'h01;
	localparam logic [7:0] RST_PC_HIGH = 8'h00;
	localparam logic [7:0] T0_MAX = 8'hff;
	localparam logic [PC_W-1:0] VEC_ADDR = 13'h0004;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_LOAD
	} cic_seq_t;
endpackage : cic_pkg

// file: hw/cic_top.sv
// Core interrupt control: flags, enables, vectoring sequence and APB registers
//
// Notes on behaviour
// - Taking an interrupt pushes only the return PC; nothing else saved.
// - Vectoring loads the PC with the fixed address 0004h.
// - Vectoring leaves the PC high latch untouched.
// - The nibble swap instruction never writes the status register.
// - Flags set on their condition regardless of own or global enable.
// - Global enable bit 7 permits unmasked interrupts; clear blocks all.
// - Peripheral group enable bit 6 gates all peripheral group requests.
// - Bit 5 enables the timer zero overflow interrupt.
// - Bit 4 enables the external pin interrupt.
// - Bit 3 enables the port B change interrupt.
// - A port B pin counts only when its change mask bit is set.
// - Timer zero flag bit 2 set on rollover, cleared only by software.
// - External pin flag bit 1 set by the event, held until cleared.
// - Port B change flag bit 0 set on any masked change, held.
// - Timer zero count keeps its value through reset.
// - External event is edge triggered; select bit picks rising or falling.
// - External flag with its enable and global enable causes a vector.
// - After wake, the instruction after sleep executes before vectoring.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module cic_top
	import cic_pkg::*;
#(
	parameter int PB_W = 8,
	parameter int PER_W = 4
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [cic_pkg::APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic T0_TICK,
	input wire logic EXT_IRQ_PIN,
	input wire logic [PB_W-1:0] PORT_B_PINS,
	input wire logic [PER_W-1:0] PERIPH_PEND,
	input wire logic CORE_AT_BOUNDARY,
	input wire logic [cic_pkg::PC_W-1:0] CORE_RET_PC,
	input wire logic CORE_RETURN,
	input wire logic CORE_SLEEPING,
	input wire logic CORE_INSN_DONE,
	input wire logic CORE_SWAP_OP,
	input wire logic CORE_STATUS_WE,
	output logic VEC_REQ,
	output logic STACK_PUSH,
	output logic [cic_pkg::PC_W-1:0] STACK_DATA,
	output logic PC_LOAD,
	output logic [cic_pkg::PC_W-1:0] PC_LOAD_VAL,
	output logic [7:0] PC_HIGH_LATCH,
	output logic WAKE,
	output logic STATUS_WE_OUT
);
	import cic_pkg::*;

	// ====================================================
	// Parameter checks
	if (PB_W < 1 || PB_W > 8) begin : g_bad_pb
		$error("PB_W must be 1 to 8");
	end
	if (PER_W < 1 || PER_W > 8) begin : g_bad_per
		$error("PER_W must be 1 to 8");
	end

	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [PB_W-1:0] mask_q;
	logic [7:0] option_q;
	logic [7:0] pch_q;
	logic [7:0] t0_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic wake_hold_q;
	logic push_q;
	logic load_q;
	logic [PC_W-1:0] stack_data_q;
	logic [PC_W-1:0] load_val_q;
	cic_seq_t seq_q;
	logic wr;
	logic setup_rd;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_t0;
	logic wr_opt;
	logic wr_pch;
	logic t0_ovf;
	logic core_hit;
	logic per_hit;
	logic take;
	logic [31:0] rd_mux;
	logic rd_err;

	cic_evt_if #(.PB_W(PB_W)) ev ();

	cic_evt_sense #(.PB_W(PB_W)) u_sense (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.ext_pin(EXT_IRQ_PIN),
		.pb_pins(PORT_B_PINS),
		.ev(ev.sense)
	);

	assign ev.edge_rise = option_q[B_EDGE_SEL];
	assign ev.chg_mask = mask_q;

	// ====================================================
	// APB decode
	assign wr = PSEL & PENABLE & PWRITE;
	assign setup_rd = PSEL & ~PENABLE & ~PWRITE;
	assign wr_ctrl = wr && PADDR == OFS_IRQ_CTRL;
	assign wr_mask = wr && PADDR == OFS_CHG_MASK;
	assign wr_t0 = wr && PADDR == OFS_T0_COUNT;
	assign wr_opt = wr && PADDR == OFS_OPTION;
	assign wr_pch = wr && PADDR == OFS_PC_HIGH;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		if (PADDR == OFS_IRQ_CTRL) begin
			rd_mux[7:0] = ctrl_q;
		end else if (PADDR == OFS_CHG_MASK) begin
			rd_mux[PB_W-1:0] = mask_q;
		end else if (PADDR == OFS_T0_COUNT) begin
			rd_mux[7:0] = t0_q;
		end else if (PADDR == OFS_OPTION) begin
			rd_mux[7:0] = option_q;
		end else if (PADDR == OFS_PC_HIGH) begin
			rd_mux[7:0] = pch_q;
		end else if (PADDR == OFS_PERIPH_STAT) begin
			rd_mux[PER_W-1:0] = PERIPH_PEND;
		end else if (PADDR == OFS_SEQ_STAT) begin
			rd_mux[B_WAKE_HOLD] = wake_hold_q;
			rd_mux[B_VEC_REQ] = VEC_REQ;
			rd_mux[B_IN_SEQ] = seq_q != SEQ_IDLE;
		end else begin
			rd_err = 1'b1;
		end
	end

	// Answer is ready in the access phase, so no wait states
	assign PREADY = 1'b1;
	assign PRDATA = prdata_q;
	assign PSLVERR = pslverr_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (PSEL & ~PENABLE) begin
			prdata_q <= setup_rd ? rd_mux : 32'h0000_0000;
			pslverr_q <= rd_err;
		end
	end

	// ====================================================
	// Plain configuration registers
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_q <= RST_CHG_MASK[PB_W-1:0];
			option_q <= RST_OPTION;
		end else begin
			if (wr_mask) begin
				mask_q <= PWDATA[PB_W-1:0];
			end
			if (wr_opt) begin
				option_q <= PWDATA[7:0];
			end
		end
	end

	// PC high latch: only software writes it, never the vector sequence
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pch_q <= RST_PC_HIGH;
		end else if (wr_pch) begin
			pch_q <= PWDATA[7:0];
		end
	end
	assign PC_HIGH_LATCH = pch_q;

	// ====================================================
	// Timer zero count
	// Deliberately no reset: software initialises it before clearing the flag
	always_ff @(posedge REF_CLK) begin
		if (wr_t0) begin
			t0_q <= PWDATA[7:0];
		end else if (T0_TICK) begin
			t0_q <= t0_q + 8'h01;
		end
	end
	assign t0_ovf = T0_TICK & ~wr_t0 & (t0_q == T0_MAX);

	// ====================================================
	// Interrupt control register
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = PWDATA[7:0];
		end
		// Hardware set beats a same-cycle software clear
		if (t0_ovf) begin
			ctrl_d[B_T0F] = 1'b1;
		end
		if (ev.ext_set) begin
			ctrl_d[B_EXTF] = 1'b1;
		end
		if (ev.chg_set) begin
			ctrl_d[B_CHGF] = 1'b1;
		end
		if (take) begin
			ctrl_d[B_ALL_EN] = 1'b0;
		end else if (CORE_RETURN) begin
			ctrl_d[B_ALL_EN] = 1'b1;
		end
	end

	// Bit 0 is undefined at reset; it comes up as zero here
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= RST_IRQ_CTRL;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ====================================================
	// Request logic
	assign core_hit = (ctrl_q[B_T0IE] & ctrl_q[B_T0F])
		| (ctrl_q[B_EXTIE] & ctrl_q[B_EXTF])
		| (ctrl_q[B_CHGIE] & ctrl_q[B_CHGF]);
	assign per_hit = ctrl_q[B_GRP_EN] & (|PERIPH_PEND);
	// A sleeping core never vectors; the instruction after sleep must run first
	assign VEC_REQ = ctrl_q[B_ALL_EN] & (core_hit | per_hit)
		& ~wake_hold_q & ~CORE_SLEEPING;
	assign take = VEC_REQ & CORE_AT_BOUNDARY & (seq_q == SEQ_IDLE);

	// Wake does not look at the global enable
	assign WAKE = CORE_SLEEPING & (core_hit | per_hit);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wake_hold_q <= 1'b0;
		end else if (WAKE) begin
			wake_hold_q <= 1'b1;
		end else if (CORE_INSN_DONE) begin
			wake_hold_q <= 1'b0;
		end
	end

	// Swap instruction must never touch status bits
	assign STATUS_WE_OUT = CORE_STATUS_WE & ~CORE_SWAP_OP;

	// ====================================================
	// Vector sequence: push cycle, then load cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			seq_q <= SEQ_IDLE;
			push_q <= 1'b0;
			load_q <= 1'b0;
			stack_data_q <= '0;
			load_val_q <= '0;
		end else begin
			push_q <= 1'b0;
			load_q <= 1'b0;
			case (seq_q)
				SEQ_IDLE: begin
					if (take) begin
						push_q <= 1'b1;
						stack_data_q <= CORE_RET_PC;
						seq_q <= SEQ_LOAD;
					end
				end
				SEQ_LOAD: begin
					load_q <= 1'b1;
					load_val_q <= VEC_ADDR;
					seq_q <= SEQ_IDLE;
				end
				default: begin
					seq_q <= SEQ_IDLE;
				end
			endcase
		end
	end

	assign STACK_PUSH = push_q;
	assign STACK_DATA = stack_data_q;
	assign PC_LOAD = load_q;
	assign PC_LOAD_VAL = load_val_q;

	// ====================================================
	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_take;
		take;
	endsequence
	sequence s_push_then_load;
		STACK_PUSH && !PC_LOAD ##1 PC_LOAD && !STACK_PUSH;
	endsequence

	AST_VEC_SEQ: assert property (s_take |=> s_push_then_load)
		else $error("vector sequence out of order");
	AST_VEC_ADDR: assert property (PC_LOAD |-> PC_LOAD_VAL == 13'h0004)
		else $error("vector address wrong");
	AST_PUSH_PC: assert property (s_take |=> STACK_DATA == $past(CORE_RET_PC))
		else $error("pushed value is not the return pc");
	AST_PCH_HOLD: assert property (s_take ##1 !$past(wr_pch) |-> $stable(pch_q))
		else $error("pc high latch changed by vectoring");
	AST_SWAP: assert property (CORE_SWAP_OP |-> !STATUS_WE_OUT)
		else $error("swap wrote status");
	AST_T0_SET: assert property (T0_TICK && !wr_t0 && t0_q == 8'hff |=> ctrl_q[B_T0F])
		else $error("timer flag not set on rollover");
	AST_EXT_SET: assert property (ev.ext_set |=> ctrl_q[B_EXTF])
		else $error("external flag not set");
	AST_CHG_SET: assert property (ev.chg_set |=> ctrl_q[B_CHGF])
		else $error("change flag not set");
	AST_GLOBAL_BLOCK: assert property (!ctrl_q[B_ALL_EN] |-> !VEC_REQ)
		else $error("request while globally disabled");
	AST_GROUP_GATE: assert property (VEC_REQ && !core_hit |-> ctrl_q[B_GRP_EN])
		else $error("peripheral request with group disabled");
	AST_EXT_REQ: assert property (ctrl_q[B_ALL_EN] && ctrl_q[B_EXTIE]
		&& ctrl_q[B_EXTF] && !wake_hold_q && !CORE_SLEEPING |-> VEC_REQ)
		else $error("external request not raised");
	AST_NO_NEST: assert property (s_take |=> !ctrl_q[B_ALL_EN] && !VEC_REQ)
		else $error("global enable not cleared on vector");

	// ====================================================
	// Wake, return and sticky flag checks
	sequence s_wake_held;
		!take ##1 (wake_hold_q && !take);
	endsequence

	AST_WAKE_HOLD: assert property (WAKE |-> s_wake_held)
		else $error("vector before post-sleep instruction");
	AST_SLEEP_BLOCK: assert property (CORE_SLEEPING |-> !VEC_REQ)
		else $error("vector request while core sleeps");
	AST_WAKE_RELEASE: assert property (wake_hold_q && CORE_INSN_DONE && !WAKE
		|=> !wake_hold_q)
		else $error("wake hold not released");
	AST_RET_SET: assert property (CORE_RETURN && !take |=> ctrl_q[B_ALL_EN])
		else $error("return did not restore global enable");
	AST_T0F_STICKY: assert property (ctrl_q[B_T0F] && !wr_ctrl |=> ctrl_q[B_T0F])
		else $error("timer flag cleared without a write");
	AST_EXTF_STICKY: assert property (ctrl_q[B_EXTF] && !wr_ctrl |=> ctrl_q[B_EXTF])
		else $error("external flag cleared without a write");
	AST_CHGF_STICKY: assert property (ctrl_q[B_CHGF] && !wr_ctrl |=> ctrl_q[B_CHGF])
		else $error("change flag cleared without a write");
endmodule : cic_top

// file: tb/cic_core_model.sv
// Model of the processor sequencer that takes vectors and returns from service
`timescale 1ns/1ps
module cic_core_model
	import cic_pkg::*;
#(
	parameter int SVC = 20,
	parameter logic [cic_pkg::PC_W-1:0] RET_PC = 13'h0a53
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic stack_push,
	input wire logic pc_load,
	output logic at_boundary,
	output logic [cic_pkg::PC_W-1:0] ret_pc,
	output logic ret_pulse,
	output logic insn_done
);
	int cnt_q;
	// ==========================================
	// Service routine length, then return
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 0;
			ret_pulse <= 1'b0;
		end else begin
			ret_pulse <= (cnt_q == 1);
			if (pc_load) begin
				cnt_q <= SVC;
			end else if (cnt_q > 0) begin
				cnt_q <= cnt_q - 1;
			end
		end
	end
	// ==========================================
	// Instructions retire every other cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			insn_done <= 1'b0;
		end else begin
			insn_done <= ~insn_done;
		end
	end
	// No boundary while a vector is pushed or a service routine runs
	assign at_boundary = !hold && !stack_push && cnt_q == 0;
	assign ret_pc = RET_PC;
endmodule : cic_core_model

// file: tb/cic_top_bench.sv
// Testbench: register access, event flags, gating and vectoring
`timescale 1ns/1ps
module cic_top_bench;
	import cic_pkg::*;
	localparam logic [PC_W-1:0] RET = 13'h0a53;
	localparam logic [9:0] TBL [10] = '{10'h07f, 10'h2a4, 10'h084, 10'h289, 10'h081,
		10'h292, 10'h082, 10'h3c0, 10'h180, 10'h140};
	logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, T0_TICK = 0;
	logic EXT_IRQ_PIN = 0, CORE_SWAP_OP = 0, CORE_STATUS_WE = 0, hold = 1, CORE_SLEEPING = 0;
	logic [7:0] PADDR = 0, PORT_B_PINS = 0, PC_HIGH_LATCH, pb = 0;
	logic [31:0] PWDATA = 0, PRDATA, seed = 32'd51755;
	logic [3:0] PERIPH_PEND = 0;
	logic PREADY, PSLVERR, CORE_AT_BOUNDARY, CORE_RETURN, CORE_INSN_DONE, VEC_REQ;
	logic STACK_PUSH, PC_LOAD, WAKE, STATUS_WE_OUT;
	logic [PC_W-1:0] CORE_RET_PC, STACK_DATA, PC_LOAD_VAL;
	logic [32:0] exp_q[$];
	logic [PC_W-1:0] vec_q[$];
	int mismatches = 0, compares = 0;

	always #25 REF_CLK = ~REF_CLK;

	cic_top cic_top_inst (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .T0_TICK, .EXT_IRQ_PIN, .PORT_B_PINS, .PERIPH_PEND,
		.CORE_AT_BOUNDARY, .CORE_RET_PC, .CORE_RETURN, .CORE_SLEEPING,
		.CORE_INSN_DONE, .CORE_SWAP_OP, .CORE_STATUS_WE, .VEC_REQ, .STACK_PUSH,
		.STACK_DATA, .PC_LOAD, .PC_LOAD_VAL, .PC_HIGH_LATCH, .WAKE, .STATUS_WE_OUT);
	cic_core_model #(.SVC(20), .RET_PC(RET)) cic_core_model_inst (.clk(REF_CLK),
		.rst_n(RST_N), .hold, .stack_push(STACK_PUSH), .pc_load(PC_LOAD),
		.at_boundary(CORE_AT_BOUNDARY), .ret_pc(CORE_RET_PC), .ret_pulse(CORE_RETURN),
		.insn_done(CORE_INSN_DONE));

	// ==========================================
	// Shared helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		compares++;
		if (seen !== want) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask : cyc

	// Caller stands just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		// PREADY ends this wait; it is tied high, so the first access-phase edge ends it
		do begin
			@(posedge REF_CLK);
		end while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge REF_CLK);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic close_out();
		$display("Counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	// ==========================================
	// Monitor: oldest note against each result
	always @(posedge REF_CLK) begin
		if (RST_N && PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
			chk({PSLVERR, PRDATA}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
		end
		if (STACK_PUSH === 1'b1) begin
			chk(STACK_DATA, vec_q.size() > 0 ? vec_q.pop_front() : 'x);
		end
		if (PC_LOAD === 1'b1) begin
			chk(PC_LOAD_VAL, VEC_ADDR);
		end
	end

	initial begin
		repeat (4000) @(posedge REF_CLK);
		mismatches++;
		close_out();
	end

	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] r;
		int n;
		repeat (6) @(posedge REF_CLK);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
		rd(OFS_IRQ_CTRL, 33'h0);
		rd(OFS_CHG_MASK, 33'h0);
		rd(OFS_OPTION, 33'h1);
		rd(OFS_PC_HIGH, 33'h0);
		rd(OFS_SEQ_STAT, 33'h0);
		rd(8'h1c, 33'h100000000);
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			r = xs();
			wr(OFS_CHG_MASK, r[7:0]);
			wr(OFS_IRQ_CTRL, 0);
			PORT_B_PINS <= r[15:8];
			cyc(2);
			rd(OFS_IRQ_CTRL, |((r[15:8] ^ pb) & r[7:0]));
			pb = r[15:8];
		end
		$display("port change done");
		wr(OFS_IRQ_CTRL, 0);
		wr(OFS_T0_COUNT, 8'hff);
		T0_TICK <= 1'b1;
		@(posedge REF_CLK);
		T0_TICK <= 1'b0;
		EXT_IRQ_PIN <= 1'b1;
		cyc(3);
		rd(OFS_IRQ_CTRL, 33'h06);
		rd(OFS_T0_COUNT, 33'h0);
		wr(OFS_IRQ_CTRL, 0);
		wr(OFS_OPTION, 0);
		EXT_IRQ_PIN <= 1'b0;
		cyc(2);
		rd(OFS_IRQ_CTRL, 33'h02);
		wr(OFS_IRQ_CTRL, 0);
		EXT_IRQ_PIN <= 1'b1;
		cyc(2);
		rd(OFS_IRQ_CTRL, 33'h0);
		$display("flag events done");
		foreach (TBL[i]) begin
			PERIPH_PEND <= {3'b0, TBL[i][8]};
			wr(OFS_IRQ_CTRL, TBL[i][7:0]);
			rd(OFS_PERIPH_STAT, TBL[i][8]);
			rd(OFS_SEQ_STAT, {TBL[i][9], 1'b0});
		end
		PERIPH_PEND <= 4'h0;
		wr(OFS_IRQ_CTRL, 0);
		hold <= 1'b0;
		CORE_STATUS_WE <= 1'b1;
		CORE_SWAP_OP <= 1'b1;
		@(posedge REF_CLK);
		chk(STATUS_WE_OUT, 0);
		CORE_SWAP_OP <= 1'b0;
		@(posedge REF_CLK);
		chk(STATUS_WE_OUT, 1);
		CORE_STATUS_WE <= 1'b0;
		$display("gating done");
		wr(OFS_PC_HIGH, 8'h5a);
		wr(OFS_IRQ_CTRL, 8'h90);
		vec_q.push_back(RET);
		EXT_IRQ_PIN <= 1'b0;
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (PC_LOAD !== 1'b1 && n < 20);
		chk(n < 20, 1);
		rd(OFS_IRQ_CTRL, 33'h12);
		rd(OFS_PC_HIGH, 33'h5a);
		chk(PC_HIGH_LATCH, 8'h5a);
		wr(OFS_IRQ_CTRL, 0);
		cyc(30);
		rd(OFS_IRQ_CTRL, 33'h80);
		wr(OFS_IRQ_CTRL, 0);
		$display("vectoring done");
		wr(OFS_OPTION, 8'h01);
		CORE_SLEEPING <= 1'b1;
		wr(OFS_IRQ_CTRL, 8'h90);
		vec_q.push_back(RET);
		EXT_IRQ_PIN <= 1'b1;
		cyc(2);
		chk(WAKE, 1);
		chk(VEC_REQ, 0);
		CORE_SLEEPING <= 1'b0;
		rd(OFS_SEQ_STAT, 33'h1);
		cyc(6);
		chk(vec_q.size(), 0);
		wr(OFS_IRQ_CTRL, 0);
		$display("wake done");
		wr(OFS_T0_COUNT, 8'h37);
		RST_N <= 1'b0;
		cyc(2);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
		rd(OFS_T0_COUNT, 33'h37);
		rd(OFS_IRQ_CTRL, 33'h0);
		$display("second reset done");
		close_out();
	end
endmodule : cic_top_bench
